// ==== bench/aolc_chk.sv ====
// Checker for the latch, checksum and lock block, on its top-level ports.
// Assumes the host spaces writes by eight link cycles; bound into aolc_top.
`timescale 1ns/100ps
module aolc_chk #(
  parameter int NCH = 6,
  parameter int RES_W = 24
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic [NCH-1:0] result_ready_i,
  input wire logic [NCH-1:0] chan_active_i,
  input wire logic sample_ready_pin_n_o,
  input wire logic sck_i,
  input wire logic wr_en_i,
  input wire logic [4:0] wr_addr_i,
  input wire logic wr_taken_o,
  input wire logic [23:0] lock_crc_rd_o
);
  logic nxt_cap;
  logic cap_ff;
  logic key_open;
  // ==========
  // Capture history, so that a falling pin can be traced to its cause.
  always_comb begin
    nxt_cap = clk_en_i && ((result_ready_i & chan_active_i) != '0);
  end
  always_ff @(posedge core_clk_i) begin
    cap_ff <= resetn_i ? (clk_en_i && result_ready_i != '0) : 1'b0;
  end
  assign key_open = (lock_crc_rd_o[23:16] == aolc_pkg::LOCK_KEY);
  // ==========
  // Assertions
  AST_PIN_PULSE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    nxt_cap |=> !sample_ready_pin_n_o) else $error("ready pin not low after capture");
  AST_PIN_CAUSE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    $fell(sample_ready_pin_n_o) |-> cap_ff || !key_open)
    else $error("ready pin fell with no capture");
  AST_PIN_ONE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    $fell(sample_ready_pin_n_o) && key_open && result_ready_i == '0 |=> sample_ready_pin_n_o)
    else $error("ready pin held low while unlocked");
  AST_WR_KEY: assert property (@(posedge sck_i) disable iff (!resetn_i)
    wr_en_i && wr_addr_i == aolc_pkg::LOCK_CRC_ADDR |=> wr_taken_o)
    else $error("key write not taken");
  AST_WR_LOW: assert property (@(posedge sck_i) disable iff (!resetn_i)
    wr_en_i && wr_addr_i < aolc_pkg::WR_FIRST_ADDR |=> !wr_taken_o)
    else $error("write to result address taken");
  AST_WR_LOCKED: assert property (@(posedge sck_i) disable iff (!resetn_i)
    wr_en_i && wr_addr_i != aolc_pkg::LOCK_CRC_ADDR && !key_open |=> !wr_taken_o)
    else $error("write taken while locked");
  AST_WR_OPEN: assert property (@(posedge sck_i) disable iff (!resetn_i)
    wr_en_i && wr_addr_i >= aolc_pkg::WR_FIRST_ADDR && key_open |=> wr_taken_o)
    else $error("write refused while unlocked");
  AST_WR_ONE: assert property (@(posedge sck_i) disable iff (!resetn_i)
    $rose(wr_taken_o) |-> $past(wr_en_i) ##1 !wr_taken_o)
    else $error("write taken pulse malformed");
  AST_FIELD_ZERO: assert property (@(posedge sck_i) disable iff (!resetn_i)
    key_open [*8] |-> lock_crc_rd_o[15:0] == 16'h0000)
    else $error("config checksum nonzero while unlocked");
endmodule // aolc_chk

bind aolc_top aolc_chk #(.NCH(NCH), .RES_W(RES_W)) u_aolc_chk (.core_clk_i(core_clk_i),
  .resetn_i(resetn_i), .clk_en_i(clk_en_i), .result_ready_i(result_ready_i),
  .chan_active_i(chan_active_i), .sample_ready_pin_n_o(sample_ready_pin_n_o), .sck_i(sck_i),
  .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i), .wr_taken_o(wr_taken_o),
  .lock_crc_rd_o(lock_crc_rd_o));

// ==== bench/aolc_host.sv ====
// Host model on the serial side: makes the link clock and the strobes.
// Assumes one caller at a time; the clock stands low between frames.
`timescale 1ns/100ps
module aolc_host (
  output logic sck_o,
  output logic seq_start_o,
  output logic rd_start_o,
  output logic [2:0] rd_chan_o,
  output logic shift_o,
  output logic seq_end_o,
  output logic wr_en_o,
  output logic [4:0] wr_addr_o,
  output logic [23:0] wr_data_o,
  input wire logic sdo_i,
  input wire logic wr_taken_i
);
  logic bits[$];
  logic taken;
  logic sh_smp;
  logic [2:0] ch_n = 3'h0;
  logic [4:0] a_n = 5'h00;
  logic [23:0] d_n = 24'h000000;
  initial begin
    {sck_o, seq_start_o, rd_start_o, shift_o, seq_end_o, wr_en_o} = '0;
    rd_chan_o = 3'h0;
    wr_addr_o = 5'h00;
    wr_data_o = 24'h000000;
  end
  // ==========
  // One link cycle. Uneven half periods keep the rising edges off the core clock edges.
  task automatic tick(input logic [4:0] s);
    #2.9;
    sck_o = 1'b1;
    sh_smp = shift_o;
    taken = taken | wr_taken_i;
    {seq_start_o, rd_start_o, shift_o, seq_end_o, wr_en_o} <= s;
    rd_chan_o <= ch_n;
    wr_addr_o <= a_n;
    wr_data_o <= d_n;
    #3.1;
    sck_o = 1'b0;
    if (sh_smp) begin
      bits.push_back(sdo_i);
    end
  endtask
  task automatic rd_seq(input int nch, input int ncrc);
    bits.delete();
    tick(5'h10);
    for (int c = 0; c < nch; c++) begin
      ch_n = 3'(c);
      tick(5'h08);
      ch_n = ~ch_n;
      repeat (24) tick(5'h04);
    end
    tick(5'h02);
    repeat (ncrc) tick(5'h04);
    repeat (3) tick(5'h00);
  endtask
  // Released lines show the inverse, so a stale value is never mistaken.
  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    a_n = a;
    d_n = d;
    taken = 1'b0;
    tick(5'h01);
    a_n = ~a;
    d_n = ~d;
    repeat (8) tick(5'h00);
  endtask
endmodule // aolc_host

// ==== bench/tb_top.sv ====
// Self-checking bench: core side driven here, link side by the host model.
// Assumes the link bit stays set, so active channels capture together.
`timescale 1ns/100ps
module tb_top;
  logic core_clk_i;
  logic resetn_i;
  logic [143:0] result_i;
  logic [5:0] result_ready_i;
  logic [5:0] chan_active_i;
  logic sample_ready_pin_n_o, sck_i, seq_start_i, rd_start_i, shift_i, seq_end_i;
  logic wr_en_i, sdo_o, wr_taken_o;
  logic [2:0] rd_chan_i;
  logic [4:0] wr_addr_i;
  logic [23:0] wr_data_i, lock_crc_rd_o, word;
  logic [5:0] per_channel_ready_flags_o;
  logic [15:0] crc;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  aolc_top u_aolc_top (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .clk_en_i(1'b1),
    .result_i(result_i), .result_ready_i(result_ready_i), .chan_active_i(chan_active_i),
    .sample_ready_pin_n_o(sample_ready_pin_n_o), .sck_i(sck_i), .seq_start_i(seq_start_i),
    .rd_start_i(rd_start_i), .rd_chan_i(rd_chan_i), .shift_i(shift_i), .seq_end_i(seq_end_i),
    .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .sdo_o(sdo_o),
    .wr_taken_o(wr_taken_o), .lock_crc_rd_o(lock_crc_rd_o),
    .per_channel_ready_flags_o(per_channel_ready_flags_o));
  aolc_host u_aolc_host (.sck_o(sck_i), .seq_start_o(seq_start_i), .rd_start_o(rd_start_i),
    .rd_chan_o(rd_chan_i), .shift_o(shift_i), .seq_end_o(seq_end_i), .wr_en_o(wr_en_i),
    .wr_addr_o(wr_addr_i), .wr_data_o(wr_data_i), .sdo_i(sdo_o), .wr_taken_i(wr_taken_o));
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  // ==========
  // Helpers
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
    return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? aolc_pkg::CRC_POLY : 16'h0000);
  endfunction
  function automatic logic [23:0] res(input int c, input logic [23:0] base);
    return base ^ (24'h010101 << c);
  endfunction
  // The inputs are inverted after the capture, so only the first stage holds them.
  task automatic pulse(input logic [23:0] base);
    @(posedge core_clk_i);
    for (int c = 0; c < 6; c++) begin
      result_i[c*24 +: 24] <= res(c, base);
    end
    result_ready_i <= 6'h3F;
    @(posedge core_clk_i);
    result_ready_i <= 6'h00;
    result_i <= ~result_i;
    #1 chk("pin_low", 32'(sample_ready_pin_n_o), 32'h00000000);
    @(posedge core_clk_i);
    #1 chk("pin_high", 32'(sample_ready_pin_n_o), 32'h00000001);
  endtask
  task automatic wr_chk(input logic [4:0] a, input logic [23:0] d, input logic exp);
    u_aolc_host.wr(a, d);
    chk("write_taken", 32'(u_aolc_host.taken), 32'(exp));
  endtask
  task automatic settle();
    repeat (2) @(posedge core_clk_i);
    repeat (4) u_aolc_host.tick(5'h00);
  endtask
  task automatic cmp_read(input int nch, input int ncrc, input logic [23:0] b0,
                          input logic [23:0] b1);
    logic [23:0] w;
    logic [31:0] got;
    logic [31:0] exp;
    crc = aolc_pkg::CRC_SEED;
    chk("bit_count", 32'(u_aolc_host.bits.size()), 32'(nch * 24 + ncrc));
    for (int c = 0; c < nch; c++) begin
      w = (c == 0) ? res(0, b0) : res(c, b1);
      got = '0;
      for (int i = 0; i < 24; i++) begin
        crc = crc_bit(crc, w[23-i]);
        got = {got[30:0], u_aolc_host.bits[c*24+i]};
      end
      chk("result_word", got, 32'(w));
    end
    got = '0;
    for (int i = 0; i < ncrc; i++) begin
      got = {got[30:0], u_aolc_host.bits[nch*24+i]};
    end
    exp = (ncrc == 32) ? {crc, 16'h0000} : {16'h0000, crc};
    chk("comm_crc", got, exp);
    for (int i = 0; i < 16; i++) begin
      crc = crc_bit(crc, u_aolc_host.bits[nch*24+i]);
    end
    chk("crc_residue", 32'(crc), 32'h00000000);
  endtask
  // ==========
  // Tests
  initial begin
    resetn_i = 1'b0;
    result_i = '0;
    result_ready_i = 6'h00;
    chan_active_i = 6'h3F;
    repeat (4) u_aolc_host.tick(5'h00);
    @(posedge core_clk_i);
    resetn_i <= 1'b1;
    repeat (4) u_aolc_host.tick(5'h00);
    chk("lock_crc_reset", 32'(lock_crc_rd_o), 32'h00A50000);
    chk("pin_reset", 32'(sample_ready_pin_n_o), 32'h00000001);
    chk("flags_reset", 32'(per_channel_ready_flags_o), 32'h0000003F);
    $display("test reset done");
    wr_chk(5'h0A, 24'h0C0000, 1'b1);
    wr_chk(5'h05, 24'h123456, 1'b0);
    pulse(24'h3C5A96);
    settle();
    chk("flags_new", 32'(per_channel_ready_flags_o), 32'h00000000);
    fork
      u_aolc_host.rd_seq(6, 16);
      begin
        repeat (20) @(posedge core_clk_i);
        pulse(24'hC3A569);
      end
    join
    cmp_read(6, 16, 24'h3C5A96, 24'hC3A569);
    chk("flags_read", 32'(per_channel_ready_flags_o), 32'h0000003E);
    $display("test read done");
    wr_chk(5'h0A, 24'h0E0000, 1'b1);
    @(posedge core_clk_i);
    chan_active_i <= 6'h02;
    pulse(24'h5A0FF0);
    settle();
    u_aolc_host.rd_seq(2, 32);
    cmp_read(2, 32, 24'hC3A569, 24'h5A0FF0);
    $display("test frame done");
    @(posedge core_clk_i);
    chan_active_i <= 6'h3F;
    wr_chk(5'h0A, 24'h0F0000, 1'b1);
    wr_chk(5'h1F, 24'h000000, 1'b1);
    wr_chk(5'h0A, 24'h080000, 1'b0);
    pulse(24'h0F0F0F);
    repeat (200) @(posedge core_clk_i);
    repeat (6) u_aolc_host.tick(5'h00);
    crc = aolc_pkg::CRC_SEED;
    for (int a = 9; a <= 31; a++) begin
      word = (a == 10) ? 24'h0F003F : 24'h000000;
      for (int i = 23; i >= 0; i--) begin
        crc = crc_bit(crc, word[i]);
      end
    end
    chk("config_crc", 32'(lock_crc_rd_o), {16'h0000, crc});
    chk("no_alarm", 32'(sample_ready_pin_n_o), 32'h00000001);
    wr_chk(5'h1F, 24'hA50000, 1'b1);
    chk("unlocked", 32'(lock_crc_rd_o), 32'h00A50000);
    pulse(24'h123ABC);
    wr_chk(5'h0A, 24'h080000, 1'b1);
    settle();
    u_aolc_host.rd_seq(1, 16);
    word = res(0, 24'h123ABC);
    crc = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      crc = {crc[14:0], u_aolc_host.bits[24+i]};
    end
    chk("crc_off", 32'(crc), {16'h0000, {16{word[0]}}});
    $display("test lock done");
    final_report();
  end
endmodule // tb_top

// ==== core/aolc_crc16.sv ====
// CRC-16 engine taking W message bits per enabled cycle, MSB first.
// Assumes clr and en are never high together on purpose; clr wins.
`timescale 1ns/100ps
module aolc_crc16 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  aolc_crc_if.eng crc_if
);
  logic [15:0] crc_ff;
  logic [15:0] nxt_crc;

  // ==========================================================================
  // Division by the generator polynomial
  always_comb begin
    nxt_crc = crc_ff;
    if (crc_if.clr) begin
      nxt_crc = aolc_pkg::CRC_SEED;
    end else if (crc_if.en) begin
      for (int i = W - 1; i >= 0; i--) begin
        if (nxt_crc[15] ^ crc_if.data[i]) begin
          nxt_crc = {nxt_crc[14:0], 1'b0} ^ aolc_pkg::CRC_POLY;
        end else begin
          nxt_crc = {nxt_crc[14:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      crc_ff <= aolc_pkg::CRC_SEED;
    end else if (ce_i) begin
      crc_ff <= nxt_crc;
    end
  end

  assign crc_if.crc = crc_ff;
endmodule // aolc_crc16

// ==== core/aolc_sync2.sv ====
// Two-stage level synchroniser with clock enable.
// Assumes each bit is a level or a toggle that holds for two edges.
`timescale 1ns/100ps
module aolc_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_q;

  // ==========================================================================
  // Stages
  always_comb begin
    nxt_meta = ce_i ? d_i : meta_ff;
    nxt_q = ce_i ? meta_ff : q_ff;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      q_ff <= nxt_q;
    end
  end

  assign q_o = q_ff;
endmodule // aolc_sync2

// ==== core/aolc_top.sv ====
// Output latches, read checksum, write lock and configuration checksum.
// Assumes an outside serial front end on sck_i that sequences addresses
// and presents reads, shifts and writes as single sck_i cycle strobes.
`timescale 1ns/100ps
// Contract
// - Results pass two latch stages in series.
// - Stage one captures on ready; link captures all. The code captures only active channels in link mode.
// - Stage two freezes a result at read start.
// - Enable bit appends checksum after read sequence.
// - Read checksum polynomial is 0x8005.
// - Checksum is 16 bits, framed as 16 or 32.
// - Checksum only after last address of set.
// - Lock key at 0x1F resets to 0xA5.
// - Locked map ignores writes except to 0x1F.
// - Config checksum runs only while locked, else zero.
// - Config checksum takes and repeats every 21 periods.
// - Resets clear the config checksum field.
// - Message is 0x09..0x1F, flags ones, field zeros.
// - Enabled unexplained change holds ready pin low.
// - First checksum is reference; mismatch latches low.
// - Unlock or reset drops reference and interrupt.
// - Power-up is unlocked with no interrupt.
// - Ready result gives half-period low pulse.
// - Unwritable address write has no effect, no advance.
module aolc_top #(
  parameter int NCH = aolc_pkg::NCH,
  parameter int RES_W = aolc_pkg::RES_W
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic [NCH*RES_W-1:0] result_i,
  input wire logic [NCH-1:0] result_ready_i,
  input wire logic [NCH-1:0] chan_active_i,
  output logic sample_ready_pin_n_o,
  input wire logic sck_i,
  input wire logic seq_start_i,
  input wire logic rd_start_i,
  input wire logic [2:0] rd_chan_i,
  input wire logic shift_i,
  input wire logic seq_end_i,
  input wire logic wr_en_i,
  input wire logic [4:0] wr_addr_i,
  input wire logic [23:0] wr_data_i,
  output logic sdo_o,
  output logic wr_taken_o,
  output logic [23:0] lock_crc_rd_o,
  output logic [NCH-1:0] per_channel_ready_flags_o
);
  localparam int CW = aolc_pkg::CFG_CHUNK_W;
  localparam int NP = aolc_pkg::CFG_CRC_PERIODS;
  localparam int MW = CW * NP;
  localparam int RW = aolc_pkg::REG_W;
  localparam int NW = aolc_pkg::CFG_WORDS - 1;
  localparam int SI = aolc_pkg::STATUS_IDX;

  typedef enum logic {CS_IDLE, CS_RUN} aolc_cs_type;

  // ==========================================================================
  // Core domain state
  logic div_ff, nxt_div;
  logic [NCH-1:0][RES_W-1:0] s1_ff, nxt_s1;
  logic upd_tgl_ff, nxt_upd_tgl;
  logic [NCH-1:0] flags_ff, nxt_flags;
  logic [NW-1:0][RW-1:0] cfg_ff, nxt_cfg;
  logic [7:0] lock_ff, nxt_lock;
  aolc_cs_type state_ff, nxt_state;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [15:0] field_ff, nxt_field;
  logic [15:0] ref_ff, nxt_ref;
  logic ref_ok_ff, nxt_ref_ok;
  logic irq_ff, nxt_irq;
  logic crc_tgl_ff, nxt_crc_tgl;
  logic pin_n_ff, nxt_pin_n;
  logic [NCH:0] seen_ff, nxt_seen;
  logic [NCH:0] req_s;
  logic [NCH-1:0] cap;
  logic [NCH-1:0] rd_ev;
  logic wr_ev;
  logic [MW-1:0] msg;
  logic [4:0] csel;

  // ==========================================================================
  // Link domain state
  logic srst_n;
  logic [NCH+3:0] sk_s;
  logic [1:0] sk_seen_ff, nxt_sk_seen;
  logic [NCH-1:0][RES_W-1:0] hold_ff, nxt_hold;
  logic [7:0] key_ff, nxt_key;
  logic [15:0] crcv_ff, nxt_crcv;
  logic [4:0] wa_ff, nxt_wa;
  logic [23:0] wd_ff, nxt_wd;
  logic wtgl_ff, nxt_wtgl;
  logic wtaken_ff, nxt_wtaken;
  logic [NCH-1:0] rtgl_ff, nxt_rtgl;
  logic [aolc_pkg::SH_W-1:0] sh_ff, nxt_sh;
  logic [5:0] left_ff, nxt_left;
  logic crcph_ff, nxt_crcph;
  logic sdo_ff, nxt_sdo;
  logic wr_ok;

  aolc_crc_if #(.W(CW)) cfg_crc ();
  aolc_crc_if #(.W(1)) com_crc ();

  // ==========================================================================
  // Crossings
  // Write requests and read-start events reach the core as toggles; the
  // held address and data stay still until the core has seen the toggle.
  aolc_sync2 #(.W(NCH+1)) u_core_sync (
    .clk_i(core_clk_i),
    .rstn_i(resetn_i),
    .ce_i(clk_en_i),
    .d_i({wtgl_ff, rtgl_ff}),
    .q_o(req_s)
  );

  aolc_sync2 #(.W(1)) u_srst_sync (
    .clk_i(sck_i),
    .rstn_i(1'b1),
    .ce_i(1'b1),
    .d_i(resetn_i),
    .q_o(srst_n)
  );

  aolc_sync2 #(.W(NCH+4)) u_link_sync (
    .clk_i(sck_i),
    .rstn_i(srst_n),
    .ce_i(1'b1),
    .d_i({upd_tgl_ff, crc_tgl_ff, cfg_ff[SI][aolc_pkg::ST_CRC_W32],
          cfg_ff[SI][aolc_pkg::ST_COMM_CRC_EN], flags_ff}),
    .q_o(sk_s)
  );

  aolc_crc16 #(.W(CW)) u_cfg_crc (
    .clk_i(core_clk_i),
    .rstn_i(resetn_i),
    .ce_i(clk_en_i),
    .crc_if(cfg_crc.eng)
  );

  aolc_crc16 #(.W(1)) u_com_crc (
    .clk_i(sck_i),
    .rstn_i(srst_n),
    .ce_i(1'b1),
    .crc_if(com_crc.eng)
  );

  // ==========================================================================
  // Configuration checksum message
  // Leading zero padding leaves a zero-seeded checksum unchanged, so the
  // message splits into equal slices, one per modulator period.
  always_comb begin
    logic [RW-1:0] w;
    w = '0;
    msg = '0;
    for (int k = 0; k < NW; k++) begin
      w = cfg_ff[k];
      if (k == SI) begin
        w[aolc_pkg::ST_RDY_LSB +: NCH] = '1;
      end
      msg[aolc_pkg::CFG_MSG_W-1-k*RW -: RW] = w;
    end
    msg[RW-1:0] = {lock_ff, 16'h0000};
    csel = (cnt_ff < 5'(NP)) ? 5'(NP - 1) - cnt_ff : 5'h00;
  end

  // ==========================================================================
  // Core domain next state
  always_comb begin
    nxt_div = ~div_ff;
    nxt_seen = req_s;
    wr_ev = req_s[NCH] ^ seen_ff[NCH];
    rd_ev = req_s[NCH-1:0] ^ seen_ff[NCH-1:0];
    nxt_s1 = s1_ff;
    nxt_upd_tgl = upd_tgl_ff;
    for (int c = 0; c < NCH; c++) begin
      cap[c] = cfg_ff[SI][aolc_pkg::ST_LINK] ?
               (|result_ready_i) & chan_active_i[c] : result_ready_i[c];
      if (cap[c]) begin
        nxt_s1[c] = result_i[c*RES_W +: RES_W];
      end
    end
    if (|cap) begin
      nxt_upd_tgl = ~upd_tgl_ff;
    end
    // A new result wins over a read that sets its flag in the same cycle.
    nxt_flags = (flags_ff | rd_ev) & ~cap;
    nxt_cfg = cfg_ff;
    nxt_lock = lock_ff;
    if (wr_ev) begin
      if (wa_ff == aolc_pkg::LOCK_CRC_ADDR) begin
        nxt_lock = wd_ff[aolc_pkg::LOCK_LSB +: 8];
      end else if (wa_ff >= aolc_pkg::CFG_FIRST_ADDR) begin
        nxt_cfg[wa_ff - aolc_pkg::CFG_FIRST_ADDR] = wd_ff;
      end
    end
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_field = field_ff;
    nxt_ref = ref_ff;
    nxt_ref_ok = ref_ok_ff;
    nxt_irq = irq_ff;
    nxt_crc_tgl = crc_tgl_ff;
    cfg_crc.clr = 1'b0;
    cfg_crc.en = 1'b0;
    cfg_crc.data = msg[csel*CW +: CW];
    unique case (state_ff)
      CS_IDLE: begin
        if (lock_ff != aolc_pkg::LOCK_KEY) begin
          nxt_state = CS_RUN;
          nxt_cnt = 5'h00;
          cfg_crc.clr = 1'b1;
        end
      end
      CS_RUN: begin
        if (lock_ff == aolc_pkg::LOCK_KEY) begin
          nxt_state = CS_IDLE;
          nxt_field = 16'h0000;
          nxt_ref_ok = 1'b0;
          nxt_irq = 1'b0;
          // The link clock may stop between frames, so the toggle moves only on a
          // real change of the field; equal passes cannot cancel each other out.
          nxt_crc_tgl = crc_tgl_ff ^ (field_ff != 16'h0000);
        end else if (wr_ev) begin
          // A processed write legitimately changes the map: re-reference.
          nxt_cnt = 5'h00;
          nxt_ref_ok = 1'b0;
          cfg_crc.clr = 1'b1;
        end else if (cnt_ff == 5'(NP)) begin
          nxt_field = cfg_crc.crc;
          nxt_crc_tgl = crc_tgl_ff ^ (cfg_crc.crc != field_ff);
          nxt_cnt = 5'h00;
          cfg_crc.clr = 1'b1;
          if (!ref_ok_ff) begin
            nxt_ref = cfg_crc.crc;
            nxt_ref_ok = 1'b1;
          end else if (cfg_crc.crc != ref_ff && cfg_ff[SI][aolc_pkg::ST_EN_INT]) begin
            nxt_irq = 1'b1;
          end
        end else if (div_ff) begin
          cfg_crc.en = 1'b1;
          nxt_cnt = cnt_ff + 5'h01;
        end
      end
    endcase
    // One core cycle is half a modulator period.
    nxt_pin_n = ~(|cap) & ~irq_ff;
  end

  // ==========================================================================
  // Core domain registers
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      div_ff <= 1'b0;
      s1_ff <= '0;
      upd_tgl_ff <= 1'b0;
      flags_ff <= '1;
      for (int k = 0; k < NW; k++) begin
        cfg_ff[k] <= (k == SI) ? aolc_pkg::STATUS_RESET : aolc_pkg::CFG_RESET;
      end
      lock_ff <= aolc_pkg::LOCK_RESET;
      state_ff <= CS_IDLE;
      cnt_ff <= 5'h00;
      field_ff <= 16'h0000;
      ref_ff <= 16'h0000;
      ref_ok_ff <= 1'b0;
      irq_ff <= 1'b0;
      crc_tgl_ff <= 1'b0;
      pin_n_ff <= 1'b1;
      seen_ff <= '0;
    end else if (clk_en_i) begin
      div_ff <= nxt_div;
      s1_ff <= nxt_s1;
      upd_tgl_ff <= nxt_upd_tgl;
      flags_ff <= nxt_flags;
      cfg_ff <= nxt_cfg;
      lock_ff <= nxt_lock;
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      field_ff <= nxt_field;
      ref_ff <= nxt_ref;
      ref_ok_ff <= nxt_ref_ok;
      irq_ff <= nxt_irq;
      crc_tgl_ff <= nxt_crc_tgl;
      pin_n_ff <= nxt_pin_n;
      seen_ff <= nxt_seen;
    end
  end

  // ==========================================================================
  // Link domain next state
  always_comb begin
    nxt_sk_seen = sk_s[NCH+3:NCH+2];
    nxt_hold = hold_ff;
    if (sk_s[NCH+3] ^ sk_seen_ff[1]) begin
      nxt_hold = s1_ff;
    end
    nxt_crcv = crcv_ff;
    if (sk_s[NCH+2] ^ sk_seen_ff[0]) begin
      nxt_crcv = field_ff;
    end
    wr_ok = wr_en_i && (wr_addr_i == aolc_pkg::LOCK_CRC_ADDR ||
            (key_ff == aolc_pkg::LOCK_KEY && wr_addr_i >= aolc_pkg::WR_FIRST_ADDR));
    nxt_wtaken = wr_ok;
    nxt_wa = wa_ff;
    nxt_wd = wd_ff;
    nxt_wtgl = wtgl_ff;
    nxt_key = key_ff;
    if (wr_ok) begin
      nxt_wa = wr_addr_i;
      nxt_wd = wr_data_i;
      nxt_wtgl = ~wtgl_ff;
      if (wr_addr_i == aolc_pkg::LOCK_CRC_ADDR) begin
        nxt_key = wr_data_i[aolc_pkg::LOCK_LSB +: 8];
      end
    end
    nxt_rtgl = rtgl_ff;
    nxt_sh = sh_ff;
    nxt_left = left_ff;
    nxt_crcph = crcph_ff;
    nxt_sdo = sdo_ff;
    com_crc.clr = seq_start_i;
    com_crc.en = 1'b0;
    com_crc.data = sh_ff[aolc_pkg::SH_W-1];
    if (seq_start_i) begin
      nxt_crcph = 1'b0;
    end
    if (rd_start_i && rd_chan_i < 3'(NCH)) begin
      // The word is frozen here so later stage-one updates cannot tear it.
      nxt_sh = {hold_ff[rd_chan_i], {(aolc_pkg::SH_W-RES_W){1'b0}}};
      nxt_left = aolc_pkg::RES_BITS;
      nxt_crcph = 1'b0;
      nxt_rtgl[rd_chan_i] = ~rtgl_ff[rd_chan_i];
    end else if (seq_end_i && sk_s[NCH]) begin
      nxt_sh = {com_crc.crc, 16'h0000};
      nxt_left = sk_s[NCH+1] ? aolc_pkg::CRC_FRAME32 : aolc_pkg::CRC_FRAME16;
      nxt_crcph = 1'b1;
    end else if (shift_i && left_ff != 6'h00) begin
      nxt_sdo = sh_ff[aolc_pkg::SH_W-1];
      nxt_sh = {sh_ff[aolc_pkg::SH_W-2:0], 1'b0};
      nxt_left = left_ff - 6'h01;
      com_crc.en = ~crcph_ff;
    end
  end

  // ==========================================================================
  // Link domain registers
  always_ff @(posedge sck_i) begin
    if (!srst_n) begin
      sk_seen_ff <= 2'h0;
      hold_ff <= '0;
      key_ff <= aolc_pkg::LOCK_RESET;
      crcv_ff <= 16'h0000;
      wa_ff <= 5'h00;
      wd_ff <= 24'h000000;
      wtgl_ff <= 1'b0;
      wtaken_ff <= 1'b0;
      rtgl_ff <= '0;
      sh_ff <= '0;
      left_ff <= 6'h00;
      crcph_ff <= 1'b0;
      sdo_ff <= 1'b0;
    end else begin
      sk_seen_ff <= nxt_sk_seen;
      hold_ff <= nxt_hold;
      key_ff <= nxt_key;
      crcv_ff <= nxt_crcv;
      wa_ff <= nxt_wa;
      wd_ff <= nxt_wd;
      wtgl_ff <= nxt_wtgl;
      wtaken_ff <= nxt_wtaken;
      rtgl_ff <= nxt_rtgl;
      sh_ff <= nxt_sh;
      left_ff <= nxt_left;
      crcph_ff <= nxt_crcph;
      sdo_ff <= nxt_sdo;
    end
  end

  assign sample_ready_pin_n_o = pin_n_ff;
  assign sdo_o = sdo_ff;
  assign wr_taken_o = wtaken_ff;
  assign lock_crc_rd_o = {key_ff, crcv_ff};
  assign per_channel_ready_flags_o = sk_s[NCH-1:0];
endmodule // aolc_top

// ==== inc/aolc_crc_if.sv ====
// Carrier between a checksum engine and the logic that feeds it.
// Assumes the feeder and the engine share one clock.
`timescale 1ns/100ps
interface aolc_crc_if #(parameter int W = 1);
  logic clr;
  logic en;
  logic [W-1:0] data;
  logic [15:0] crc;
  modport eng (input clr, input en, input data, output crc);
  modport usr (output clr, output en, output data, input crc);
endinterface

// ==== inc/aolc_pkg.sv ====
// Constants of the output latch, checksum and lock block.
// Assumes the core clock runs at twice the modulator digital clock.
package aolc_pkg;
  // ==========================================================================
  // Sizes
  localparam int NCH = 6;
  localparam int RES_W = 24;
  localparam int REG_W = 24;
  localparam int SH_W = 32;
  // ==========================================================================
  // Addresses
  localparam logic [4:0] WR_FIRST_ADDR = 5'h08;
  localparam logic [4:0] CFG_FIRST_ADDR = 5'h09;
  localparam logic [4:0] LOCK_CRC_ADDR = 5'h1F;
  localparam logic [4:0] STATUS_ADDR = 5'h0A;
  localparam int STATUS_IDX = 1;
  // ==========================================================================
  // Field layout and reset values
  localparam logic [7:0] LOCK_KEY = 8'hA5;
  localparam logic [7:0] LOCK_RESET = 8'hA5;
  localparam int LOCK_LSB = 16;
  localparam int ST_RDY_LSB = 0;
  localparam int ST_EN_INT = 16;
  localparam int ST_CRC_W32 = 17;
  localparam int ST_COMM_CRC_EN = 18;
  localparam int ST_LINK = 19;
  localparam logic [23:0] STATUS_RESET = 24'h080000;
  localparam logic [23:0] CFG_RESET = 24'h000000;
  // ==========================================================================
  // Checksums and timing
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_SEED = 16'h0000;
  localparam int CFG_CRC_PERIODS = 21;
  localparam int CFG_WORDS = 23;
  localparam int CFG_MSG_W = CFG_WORDS * REG_W;
  localparam int CFG_CHUNK_W = (CFG_MSG_W + CFG_CRC_PERIODS - 1) / CFG_CRC_PERIODS;
  localparam int CFG_PAD_W = CFG_CHUNK_W * CFG_CRC_PERIODS - CFG_MSG_W;
  localparam logic [5:0] RES_BITS = 6'h18;
  localparam logic [5:0] CRC_FRAME16 = 6'h10;
  localparam logic [5:0] CRC_FRAME32 = 6'h20;
endpackage
